// ---- logic/hseq_pkg.sv ----
/*
 * Package for the homing sequencer: method codes, state encoding,
 * the switch and command carriers and the sequencer state record.
 * Assumes the switch inputs are active high and a motion controller
 * outside turns the direction and speed commands into a profile.
 */
`default_nettype none

package hseq_pkg;

	// Width of the homing method code
	localparam int unsigned METH_W_DEF = 8;

	// Supported homing method codes
	localparam logic [7:0] METH_11 = 8'h0B;
	localparam logic [7:0] METH_12 = 8'h0C;
	localparam logic [7:0] METH_13 = 8'h0D;
	localparam logic [7:0] METH_14 = 8'h0E;
	localparam logic [7:0] METH_17 = 8'h11;
	localparam logic [7:0] METH_18 = 8'h12;
	localparam logic [7:0] METH_19 = 8'h13;
	localparam logic [7:0] METH_20 = 8'h14;

	// Reset value of the stored method code
	localparam logic [7:0] METH_RST = 8'h00;

	// Sequencer phases
	typedef enum logic [2:0] {
		HS_IDLE,     // No motion, waiting for start
		HS_FAST,     // First high speed search
		HS_FAST_REV, // High speed search after reverse limit reversal
		HS_SLOW1,    // Low speed leg after the deceleration edge
		HS_SLOW2,    // Second low speed leg
		HS_INDEX,    // Low speed, waiting for the first index pulse
		HS_DONE      // Stopped at home
	} hseq_state_e;

	// Switch and index inputs travel together
	typedef struct packed {
		logic home_switch_input;          // Home (deceleration) switch
		logic forward_travel_limit_input; // Forward limit switch
		logic reverse_travel_limit_input; // Reverse limit switch
		logic index;                      // Encoder index pulse
	} hseq_sw_s;

	// Motion command towards the motor controller
	typedef struct packed {
		logic run;        // Motor commanded to move
		logic dir_neg;    // Negative direction when set
		logic high_speed; // High search speed when set, low otherwise
	} hseq_cmd_s;

	// Whole sequencer state
	typedef struct packed {
		hseq_state_e st;      // Phase
		logic [7:0]  meth;    // Method latched at start
		logic        dir_neg; // Direction command
		logic        fast;    // Speed command
		logic        done;    // One cycle done pulse
		logic        reject;  // One cycle refused start pulse
		hseq_sw_s    sw_s1;   // Synchroniser first stage
		hseq_sw_s    sw_s2;   // Synchronised copy
		hseq_sw_s    sw_s3;   // Previous synchronised copy for edges
	} hseq_regs_s;

endpackage

`default_nettype wire

// ---- logic/hseq_top.sv ----
/*
 * Homing sequencer for methods 11 to 14 and 17 to 20.
 * Assumes switch and index inputs are active high, start_i and stop_i
 * are one cycle pulses, and the motor controller obeys cmd_o.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - M11 idle start: neg fast, slow, index after fall
// - M11 reverse limit: pos fast, then neg slow
// - M11 active start: pos slow, index after fall
// - M12 idle: neg fast, pos slow, neg, index
// - M12 limit: pos fast, pos slow, neg, index
// - M12 active: pos slow, neg slow, index
// - M13 idle: neg fast, neg slow, pos, index
// - M13 limit: pos fast, pos slow throughout, index
// - M13 active: pos slow, pos slow, index
// - M14 idle: neg fast, neg slow, index after fall
// - M14 limit: pos fast, neg slow, index
// - M14 active: neg slow, index after fall
// - M17 idle: neg fast, pos slow, stop on fall
// - M17 active: pos slow, stop on reverse fall
// - M18 idle: pos fast, neg slow, stop on fall
// - M18 active: neg slow, stop on forward fall
// - M19 idle: pos fast, neg slow, stop on fall
// - M19 active: neg slow, stop on home fall
// - M20 idle: pos slow, stop on home rise
// - M20 active: neg fast, pos slow, stop rise
// - Start level of switch picks the sequence
module hseq_top import hseq_pkg::*; #(
	parameter int unsigned METH_W = METH_W_DEF
) (
	input  wire logic              sys_clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              start_i,
	input  wire logic              stop_i,
	input  wire logic [METH_W-1:0] method_i,
	input  wire hseq_sw_s          sw_i,
	output var  hseq_cmd_s         cmd_o,
	output logic                   busy_o,
	output logic                   done_o,
	output logic                   reject_o
);

	// Method codes need eight bits
	if (METH_W != 8) begin : g_bad_width
		$error("hseq_top: METH_W must be 8");
	end

	hseq_regs_s r;   // Registered state
	hseq_regs_s nxt; // Next state
	hseq_sw_s   rise; // Rising edges of synchronised inputs
	hseq_sw_s   fall; // Falling edges of synchronised inputs
	logic       z_meth;   // Latched method ends on index
	logic       start_take; // Start request in a stopped phase with no stop this cycle, any method code
	logic       ref_rise; // Reference switch rising edge
	logic       ref_fall; // Reference switch falling edge

	// Edges seen on synchronised copies only
	assign rise = r.sw_s2 & ~r.sw_s3;
	assign fall = ~r.sw_s2 & r.sw_s3;

	// Start seen in a stopped phase with no abort beside it
	assign start_take = ((r.st == HS_IDLE) || (r.st == HS_DONE)) && start_i && !stop_i;

	// Supported method check
	function automatic logic meth_ok(input logic [7:0] m);
		meth_ok = (m == METH_11) || (m == METH_12) || (m == METH_13) ||
			(m == METH_14) || (m == METH_17) || (m == METH_18) ||
			(m == METH_19) || (m == METH_20);
	endfunction

	// Methods homed on the encoder index
	function automatic logic is_z(input logic [7:0] m);
		is_z = (m >= METH_11) && (m <= METH_14);
	endfunction

	// Reference switch of a method taken from a switch set
	function automatic logic ref_of(input logic [7:0] m, input hseq_sw_s s);
		if (m == METH_17) begin
			ref_of = s.reverse_travel_limit_input;
		end else if (m == METH_18) begin
			ref_of = s.forward_travel_limit_input;
		end else begin
			ref_of = s.home_switch_input;
		end
	endfunction

	// Reference signal selection for the running method
	always_comb begin
		z_meth   = is_z(r.meth);
		ref_rise = ref_of(r.meth, rise);
		ref_fall = ref_of(r.meth, fall);
	end

	// Sequencer next state
	always_comb begin
		nxt        = r;
		nxt.sw_s1  = sw_i;
		nxt.sw_s2  = r.sw_s1;
		nxt.sw_s3  = r.sw_s2;
		nxt.done   = 1'b0;
		nxt.reject = 1'b0;
		if (stop_i) begin
			// Abort from any phase
			nxt.st   = HS_IDLE;
			nxt.fast = 1'b0;
		end else begin
			case (r.st)
				HS_IDLE, HS_DONE: begin
					if (start_i && !meth_ok(method_i)) begin
						// Refused code, no motion
						nxt.reject = 1'b1;
					end else if (start_i) begin
						nxt.meth = method_i;
						if (ref_of(method_i, r.sw_s2)) begin
							// Switch active at start
							if (method_i == METH_20) begin
								nxt.st      = HS_FAST;
								nxt.fast    = 1'b1;
								nxt.dir_neg = 1'b1;
							end else begin
								nxt.st      = HS_SLOW1;
								nxt.fast    = 1'b0;
								nxt.dir_neg = (method_i == METH_14) ||
									(method_i == METH_18) || (method_i == METH_19);
							end
						end else if (method_i == METH_20) begin
							// Slow creep towards the home switch
							nxt.st      = HS_SLOW1;
							nxt.fast    = 1'b0;
							nxt.dir_neg = 1'b0;
						end else begin
							// High speed search
							nxt.st      = HS_FAST;
							nxt.fast    = 1'b1;
							nxt.dir_neg = is_z(method_i) || (method_i == METH_17);
						end
					end
				end
				HS_FAST: begin
					if (z_meth && rise.reverse_travel_limit_input) begin
						// Reverse limit met: turn back at high speed
						nxt.st      = HS_FAST_REV;
						nxt.dir_neg = 1'b0;
					end else if ((r.meth == METH_20) ? ref_fall : ref_rise) begin
						// Deceleration edge: low speed leg
						nxt.st      = HS_SLOW1;
						nxt.fast    = 1'b0;
						nxt.dir_neg = (r.meth == METH_11) || (r.meth == METH_13) ||
							(r.meth == METH_14) || (r.meth == METH_18) ||
							(r.meth == METH_19);
					end
				end
				HS_FAST_REV: begin
					if (rise.home_switch_input) begin
						// Home found after reversal
						nxt.st      = HS_SLOW1;
						nxt.fast    = 1'b0;
						nxt.dir_neg = (r.meth == METH_11) || (r.meth == METH_14);
					end
				end
				HS_SLOW1: begin
					if (z_meth) begin
						if (fall.home_switch_input) begin
							if ((r.meth == METH_11) || (r.meth == METH_14)) begin
								// Keep direction, wait for index
								nxt.st = HS_INDEX;
							end else begin
								// Second low speed leg
								nxt.st      = HS_SLOW2;
								nxt.dir_neg = (r.meth == METH_12);
							end
						end
					end else if ((r.meth == METH_20) ? ref_rise : ref_fall) begin
						// Stop on the switch edge itself
						nxt.st   = HS_DONE;
						nxt.done = 1'b1;
					end
				end
				HS_SLOW2: begin
					if (rise.home_switch_input) begin
						// Switch met again, index next
						nxt.st = HS_INDEX;
					end
				end
				HS_INDEX: begin
					if (rise.index) begin
						// First index pulse ends homing
						nxt.st   = HS_DONE;
						nxt.done = 1'b1;
					end
				end
				default: begin
					nxt.st = HS_IDLE;
				end
			endcase
		end
	end

	// State register, synchronous reset
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			r.st      <= HS_IDLE;
			r.meth    <= METH_RST;
			r.dir_neg <= 1'b0;
			r.fast    <= 1'b0;
			r.done    <= 1'b0;
			r.reject  <= 1'b0;
			r.sw_s1   <= '0;
			r.sw_s2   <= '0;
			r.sw_s3   <= '0;
		end else begin
			r <= nxt;
		end
	end

	// Outputs from state flip-flops
	always_comb begin
		cmd_o.run        = (r.st != HS_IDLE) && (r.st != HS_DONE);
		cmd_o.dir_neg    = r.dir_neg;
		cmd_o.high_speed = r.fast;
		busy_o           = cmd_o.run;
		done_o           = r.done;
		reject_o         = r.reject;
	end

	// Checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	idle_no_motion_a: assert property (
		(r.st == HS_IDLE) |-> !cmd_o.run)
		else $error("motion commanded while idle");

	bad_code_refused_a: assert property (
		(r.st == HS_IDLE) && start_i && !stop_i && !meth_ok(method_i)
		|=> (r.st == HS_IDLE) && reject_o && !cmd_o.run)
		else $error("unsupported method not refused");

	active_start_slow_a: assert property (
		start_take && is_z(method_i) &&
		r.sw_s2.home_switch_input |=> (r.st == HS_SLOW1) && !cmd_o.high_speed)
		else $error("active start did not begin slow");

	z_fast_neg_a: assert property (
		(r.st == HS_FAST) && z_meth |-> cmd_o.dir_neg && cmd_o.high_speed)
		else $error("index method search not negative fast");

	limit_reversal_a: assert property (
		(r.st == HS_FAST) && z_meth && rise.reverse_travel_limit_input && !stop_i
		|=> (r.st == HS_FAST_REV) && !cmd_o.dir_neg && cmd_o.high_speed)
		else $error("reverse limit did not reverse");

	m12_slow_pos_a: assert property (
		(r.st == HS_FAST) && (r.meth == METH_12) && rise.home_switch_input &&
		!rise.reverse_travel_limit_input && !stop_i
		|=> !cmd_o.dir_neg && !cmd_o.high_speed ##0 (r.st == HS_SLOW1))
		else $error("method 12 did not turn positive slow");

	m13_second_leg_a: assert property (
		(r.st == HS_SLOW1) && (r.meth == METH_13) && fall.home_switch_input && !stop_i
		|=> (r.st == HS_SLOW2) && !cmd_o.dir_neg)
		else $error("method 13 second leg not positive");

	index_stop_a: assert property (
		(r.st == HS_INDEX) && rise.index && !stop_i
		|=> done_o && !cmd_o.run ##1 !done_o)
		else $error("index pulse did not stop motor");

	m17_stop_a: assert property (
		(r.st == HS_SLOW1) && (r.meth == METH_17) && fall.reverse_travel_limit_input &&
		!stop_i |=> (r.st == HS_DONE) && done_o)
		else $error("method 17 did not stop on falling edge");

	m20_active_a: assert property (
		start_take && (method_i == METH_20) &&
		r.sw_s2.home_switch_input |=> (r.st == HS_FAST) && cmd_o.dir_neg && cmd_o.high_speed)
		else $error("method 20 active start not negative fast");

	// First low speed leg after a plain high speed search
	m11_slow_neg_a: assert property (
		(r.st == HS_FAST) && (r.meth == METH_11) && rise.home_switch_input &&
		!rise.reverse_travel_limit_input && !stop_i
		|=> (r.st == HS_SLOW1) && cmd_o.dir_neg && !cmd_o.high_speed)
		else $error("method 11 did not slow down negative");

	m13_slow_neg_a: assert property (
		(r.st == HS_FAST) && (r.meth == METH_13) && rise.home_switch_input &&
		!rise.reverse_travel_limit_input && !stop_i
		|=> (r.st == HS_SLOW1) && cmd_o.dir_neg && !cmd_o.high_speed)
		else $error("method 13 did not slow down negative");

	// After a limit reversal the home edge picks the low speed direction
	rev_slow_neg_a: assert property (
		(r.st == HS_FAST_REV) && rise.home_switch_input && !stop_i &&
		((r.meth == METH_11) || (r.meth == METH_14))
		|=> (r.st == HS_SLOW1) && cmd_o.dir_neg && !cmd_o.high_speed)
		else $error("reversed search did not turn negative slow");

	rev_slow_pos_a: assert property (
		(r.st == HS_FAST_REV) && rise.home_switch_input && !stop_i &&
		((r.meth == METH_12) || (r.meth == METH_13))
		|=> (r.st == HS_SLOW1) && !cmd_o.dir_neg && !cmd_o.high_speed)
		else $error("reversed search did not stay positive slow");

	// Active start legs for methods 11, 14, 17 and 18
	m11_active_pos_a: assert property (
		start_take && (method_i == METH_11) && r.sw_s2.home_switch_input
		|=> (r.st == HS_SLOW1) && !cmd_o.dir_neg && !cmd_o.high_speed)
		else $error("method 11 active start not positive slow");

	m14_active_neg_a: assert property (
		start_take && (method_i == METH_14) && r.sw_s2.home_switch_input
		|=> (r.st == HS_SLOW1) && cmd_o.dir_neg && !cmd_o.high_speed)
		else $error("method 14 active start not negative slow");

	m17_active_pos_a: assert property (
		start_take && (method_i == METH_17) && r.sw_s2.reverse_travel_limit_input
		|=> (r.st == HS_SLOW1) && !cmd_o.dir_neg && !cmd_o.high_speed)
		else $error("method 17 active start not positive slow");

	m18_active_neg_a: assert property (
		start_take && (method_i == METH_18) && r.sw_s2.forward_travel_limit_input
		|=> (r.st == HS_SLOW1) && cmd_o.dir_neg && !cmd_o.high_speed)
		else $error("method 18 active start not negative slow");

	// Low speed legs around the home switch
	m12_second_leg_a: assert property (
		(r.st == HS_SLOW1) && (r.meth == METH_12) && fall.home_switch_input && !stop_i
		|=> (r.st == HS_SLOW2) && cmd_o.dir_neg && !cmd_o.high_speed)
		else $error("method 12 second leg not negative slow");

	index_wait_a: assert property (
		(r.st == HS_SLOW1) && ((r.meth == METH_11) || (r.meth == METH_14)) &&
		fall.home_switch_input && !stop_i
		|=> (r.st == HS_INDEX) && $stable(cmd_o.dir_neg) && !cmd_o.high_speed)
		else $error("index wait changed direction or speed");

	second_rise_a: assert property (
		(r.st == HS_SLOW2) && rise.home_switch_input && !stop_i
		|=> (r.st == HS_INDEX) && cmd_o.run && !cmd_o.high_speed)
		else $error("second home edge did not arm index wait");

	m19_fast_a: assert property (
		(r.st == HS_FAST) && (r.meth == METH_19) && rise.home_switch_input && !stop_i
		|=> (r.st == HS_SLOW1) && cmd_o.dir_neg && !cmd_o.high_speed)
		else $error("method 19 did not turn negative slow");

	m20_rise_stop_a: assert property (
		(r.st == HS_SLOW1) && (r.meth == METH_20) && rise.home_switch_input && !stop_i
		|=> (r.st == HS_DONE) && done_o && !cmd_o.run)
		else $error("method 20 did not stop on rising edge");

	limit_path_c: cover property (
		(r.st == HS_FAST_REV) ##[1:1000] (r.st == HS_INDEX) ##[1:1000] done_o);

	switch_home_c: cover property ((r.st == HS_SLOW1) && !z_meth ##1 done_o);

	refused_c: cover property (reject_o);

	second_leg_c: cover property ((r.st == HS_SLOW2) ##[1:1000] done_o);

endmodule

`default_nettype wire

// ---- tb/hseq_motor_model.sv ----
/*
 * Behavioural axis model: a position that follows the motion command,
 * with two home cams, travel limits and index pulse decoded from it.
 * The second cam lets the methods that search on in the same direction
 * after the first cam meet a further rising edge.
 * Assumes the bench loads a start position only while the axis is stopped.
 */
`timescale 1ns/1ps
`default_nettype none

module hseq_motor_model import hseq_pkg::*; #(
	parameter int HOME_LO   = 400,
	parameter int HOME_HI   = 500,
	parameter int HOME2_LO  = 800,
	parameter int HOME2_HI  = 850,
	parameter int FWD_LIM   = 1000,
	parameter int IDX_PITCH = 16
) (
	input  wire logic               clk_i,
	input  wire hseq_cmd_s          cmd_i,
	input  wire logic               load_i,
	input  wire logic signed [31:0] load_pos_i,
	output var  hseq_sw_s           sw_o
);
	int pos; // Axis position in model steps

	// Move four steps a cycle at high speed, one at low speed
	always @(posedge clk_i) begin
		if (load_i) begin
			pos <= load_pos_i;
		end else if (cmd_i.run) begin
			pos <= cmd_i.dir_neg ? pos - (cmd_i.high_speed ? 4 : 1)
				: pos + (cmd_i.high_speed ? 4 : 1);
		end
	end

	// Switch levels follow the position; limits sit at both ends of travel
	always_comb begin
		sw_o.home_switch_input          = ((pos >= HOME_LO) && (pos <= HOME_HI)) ||
			((pos >= HOME2_LO) && (pos <= HOME2_HI));
		sw_o.forward_travel_limit_input = (pos >= FWD_LIM);
		sw_o.reverse_travel_limit_input = (pos <= 0);
		sw_o.index                      = ((pos % IDX_PITCH) == 0);
	end
endmodule

`default_nettype wire

// ---- tb/hseq_top_tb_top.sv ----
/*
 * Self-checking bench: runs each method from chosen start positions and
 * compares the recorded run of direction and speed legs and the done pulse.
 * Assumes the axis model in hseq_motor_model and the sequencer package.
 */
`timescale 1ns/1ps
`default_nettype none

module hseq_top_tb_top import hseq_pkg::*;;
	logic       sys_clk_i = 1'b0;
	logic       rst_n_i   = 1'b0;
	logic       start_i   = 1'b0;
	logic [7:0] method_i  = 8'h00;
	logic       load      = 1'b0;
	int         load_pos  = 700;
	hseq_sw_s   sw;
	hseq_cmd_s  cmd;
	logic       busy;
	logic       done;
	logic       reject;
	logic [7:0] legs;       // Last four legs, two bits each
	logic [7:0] nlegs;      // Legs recorded
	logic [7:0] dones;      // Done pulses seen
	logic [1:0] last;       // Previous leg code
	logic       was_run;    // Moving in previous cycle
	int         mismatches = 0;
	int         cmp_count  = 0;

	always #2 sys_clk_i = ~sys_clk_i;

	hseq_top #(.METH_W(8)) dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.start_i(start_i), .stop_i(1'b0), .method_i(method_i), .sw_i(sw),
		.cmd_o(cmd), .busy_o(busy), .done_o(done), .reject_o(reject));

	hseq_motor_model mot_u (.clk_i(sys_clk_i), .cmd_i(cmd), .load_i(load),
		.load_pos_i(load_pos), .sw_o(sw));

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (exp !== got) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Record each new leg and the done pulses at settled points
	always @(negedge sys_clk_i) begin
		if (cmd.run === 1'b1 && (!was_run || {cmd.dir_neg, cmd.high_speed} !== last)) begin
			legs  = {legs[5:0], cmd.dir_neg, cmd.high_speed};
			nlegs = nlegs + 8'h01;
		end
		if (done === 1'b1) begin
			dones = dones + 8'h01;
			chk("run at done", 8'h00, {7'h00, cmd.run});
		end
		was_run = cmd.run;
		last    = {cmd.dir_neg, cmd.high_speed};
	end

	task automatic tally_and_finish();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Place the axis, start a method, wait for home and judge the legs
	task automatic run_case(input logic [7:0] m, input int p, input logic [7:0] el,
		input logic [7:0] en);
		int i;
		@(negedge sys_clk_i) load = 1'b1;
		load_pos = p;
		@(negedge sys_clk_i) load = 1'b0;
		repeat (5) @(negedge sys_clk_i);
		legs  = 8'h00;
		nlegs = 8'h00;
		dones = 8'h00;
		method_i = m;
		start_i  = 1'b1;
		@(negedge sys_clk_i) start_i = 1'b0;
		chk("busy after start", 8'h01, {7'h00, busy});
		for (i = 0; i < 4000 && dones == 8'h00; i++) @(negedge sys_clk_i);
		@(negedge sys_clk_i);
		chk("legs", el, legs);
		chk("leg count", en, nlegs);
		chk("done pulses", 8'h01, dones);
		chk("busy at home", 8'h00, {7'h00, busy});
	endtask

	task automatic t_m11();
		run_case(METH_11, 700, 8'h0E, 8'h02);
		run_case(METH_11, 200, 8'h36, 8'h03);
		run_case(METH_11, 450, 8'h00, 8'h01);
	endtask

	task automatic t_m12();
		run_case(METH_12, 700, 8'h32, 8'h03);
		run_case(METH_12, 200, 8'hD2, 8'h04);
		run_case(METH_12, 450, 8'h02, 8'h02);
	endtask

	task automatic t_m13_m14();
		run_case(METH_13, 700, 8'h38, 8'h03);
		run_case(METH_13, 200, 8'h34, 8'h03);
		run_case(METH_13, 450, 8'h00, 8'h01);
		run_case(METH_14, 700, 8'h0E, 8'h02);
		run_case(METH_14, 200, 8'h36, 8'h03);
		run_case(METH_14, 450, 8'h02, 8'h01);
	endtask

	task automatic t_limits();
		run_case(METH_17, 200, 8'h0C, 8'h02);
		run_case(METH_17, -5, 8'h00, 8'h01);
		run_case(METH_18, 700, 8'h06, 8'h02);
		run_case(METH_18, 1005, 8'h02, 8'h01);
	endtask

	task automatic t_home_sw();
		run_case(METH_19, 200, 8'h06, 8'h02);
		run_case(METH_19, 450, 8'h02, 8'h01);
		run_case(METH_20, 200, 8'h00, 8'h01);
		run_case(METH_20, 450, 8'h0C, 8'h02);
	endtask

	// Unsupported code: refused with a pulse, axis stays still
	task automatic t_bad();
		@(negedge sys_clk_i) method_i = 8'h0F;
		start_i = 1'b1;
		@(negedge sys_clk_i) start_i = 1'b0;
		chk("reject pulse", 8'h01, {7'h00, reject});
		chk("busy on reject", 8'h00, {7'h00, busy});
		@(negedge sys_clk_i);
		chk("reject ends", 8'h00, {7'h00, reject});
		chk("command on reject", 8'h00, {5'h00, cmd});
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		#400000;
		mismatches++;
		tally_and_finish();
	end

	initial begin
		repeat (3) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		t_bad();
		t_m11();
		t_m12();
		t_m13_m14();
		t_limits();
		t_home_sw();
		tally_and_finish();
	end
endmodule

`default_nettype wire
